// ---- shared/upconv_port_pkg.sv ----
// shared types and constants for the baseband data input port
package upconv_port_pkg;
	localparam int DATA_W = 18;
	localparam int SER_W = 16;
	localparam int AMP_W = 14;
	localparam int DAC_W = 14;
	localparam int TW_W = 32;
	localparam int RATIO_W = 6;
	localparam int CNT_W = 10;
	localparam int PIN_SER_I = 0;
	localparam int PIN_SER_Q = 1;
	localparam int SINC_SHIFT = 4;
	localparam int GAIN_SHIFT = 7;
	localparam int MOD_SHIFT = 17;
	localparam int TONE_SHIFT = 14;
	localparam int INTERP_SHIFT = 4;
	localparam logic [CNT_W-1:0] PERIOD_MIN = 10'h002;
	localparam logic [3:0] SER_LAST = 4'hF;
	localparam logic [15:0] PHASE_QUARTER = 16'h4000;
	localparam logic signed [31:0] SINC_CENTER = 32'sh00000012;
	localparam logic signed [31:0] DAC_MAX = 32'sh00001FFF;
	localparam logic signed [31:0] DAC_MIN = 32'shFFFFE000;

	typedef enum logic [1:0] {
		MODE_QUAD = 2'h0,
		MODE_DAC = 2'h1,
		MODE_TONE = 2'h2
	} op_mode_type;

	typedef struct packed {
		op_mode_type mode;
		logic serial_iq;
		logic rate_ctrl;
		logic clk_invert;
		logic clk_enable;
		logic gate_invert;
		logic hold_last;
		logic q_first;
		logic offset_bin;
		logic lsb_first;
		logic inv_sinc_en;
		logic sine_sel;
		logic ramp_en;
		logic [RATIO_W-1:0] ratio;
		logic [TW_W-1:0] tuning;
		logic [AMP_W-1:0] amp_preset;
		logic [15:0] ramp_step_cycles;
		logic [7:0] out_gain;
	} ctrl_type;

	typedef struct packed {
		logic valid;
		logic signed [DATA_W-1:0] i;
		logic signed [DATA_W-1:0] q;
	} sample_type;

	localparam ctrl_type CTRL_RST = '0;
	localparam sample_type SAMPLE_RST = '0;
endpackage

// ---- logic/baseband_data_input_port.sv ----
// baseband sample port, port clock and mode datapath of the upconverter
//
// Behaviour
// - three modes, quadrature default, chosen by the mode field of control.
// - quadrature takes interleaved 18-bit I then Q words, paired into samples.
// - dual-serial mode shifts two bit streams into 16-bit I and Q words.
// - dual-serial mode enables extra half-band stages, four times interpolation.
// - in dual-serial mode the port clock is a bit clock.
// - DAC mode disables Q path, DDS and modulator; I stays at baseband.
// - DAC mode raises rate by zero stuffing and image filtering.
// - tone mode disables data paths; DDS gives cosine or sine tone.
// - tone multiplied by 14-bit amplitude scale, optional inverse sinc after.
// - amplitude keying ramps scale between zero and preset over set interval.
// - inverse sinc optional in all modes, then output scaling to 14-bit DAC.
// - modulator multiplies I and Q by cosine and sine and sums.
// - port clock at port rate; capture on rising edge, falling if inverted.
// - clock enable cleared holds pin low while capture keeps running.
// - quadrature captures one word per active edge, two cycles per pair.
// - rate control halves clock, I on rising, Q on falling; invert swaps.
// - gate polarity set by invert bit; data ignored while gate false.
// - gate false forces words to zero or holds last, per hold bit.
// - after gate rise first word is I, then alternate; Q-first reverses.
// - gate rise marks first serial bits; source sends whole 16-bit frames.
// - port clock period 2R, 4R with rate control or DAC, R in serial.
// - serial mode uses one pin for I, one for Q; others unused.
// - twos complement or offset binary input; serial MSB or LSB first.
`timescale 1ns/1ps
module baseband_data_input_port (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// configuration
	input wire upconv_port_pkg::ctrl_type ctrl,
	// port pins
	input wire logic [upconv_port_pkg::DATA_W-1:0] port_data_pin,
	input wire logic transmit_gate_pin,
	input wire logic amplitude_ramp_keying_pin,
	output logic port_sample_clock,
	// path enables
	output logic i_path_en,
	output logic q_path_en,
	output logic dds_en,
	output logic modulator_en,
	output logic extra_halfband_en,
	// samples and converter word
	output upconv_port_pkg::sample_type baseband_sample,
	output logic [upconv_port_pkg::DAC_W-1:0] dac_code
);
	localparam int DW = upconv_port_pkg::DATA_W;
	localparam int CW = upconv_port_pkg::CNT_W;
	localparam int SW = upconv_port_pkg::SER_W;
	localparam int OW = upconv_port_pkg::DAC_W;

	// port clock period in system clock cycles, never below two
	function automatic logic [CW-1:0] port_period(
		input upconv_port_pkg::ctrl_type c);
		logic [CW-1:0] r;
		logic [CW-1:0] p;
		r = (c.ratio == '0) ? 10'h001 : {4'h0, c.ratio};
		if (c.mode == upconv_port_pkg::MODE_QUAD && c.serial_iq)
			p = r;
		else if (c.mode == upconv_port_pkg::MODE_DAC || c.rate_ctrl)
			p = CW'(r << 2);
		else
			p = CW'(r << 1);
		port_period = (p < upconv_port_pkg::PERIOD_MIN) ?
			upconv_port_pkg::PERIOD_MIN : p;
	endfunction

	// offset binary becomes twos complement by flipping the sign bit
	function automatic logic signed [DW-1:0] fmt_word(
		input logic [DW-1:0] w, input logic ofs);
		fmt_word = ofs ? {~w[DW-1], w[DW-2:0]} : w;
	endfunction

	// clamp to the converter range
	function automatic logic signed [OW-1:0] sat_dac(
		input logic signed [31:0] v);
		if (v > upconv_port_pkg::DAC_MAX)
			sat_dac = upconv_port_pkg::DAC_MAX[OW-1:0];
		else if (v < upconv_port_pkg::DAC_MIN)
			sat_dac = upconv_port_pkg::DAC_MIN[OW-1:0];
		else
			sat_dac = v[OW-1:0];
	endfunction

	// triangle stands in for the sine table; spur level is worse
	function automatic logic signed [OW-1:0] tri_wave(input logic [15:0] ph);
		logic [13:0] m;
		m = ph[14] ? ~ph[13:0] : ph[13:0];
		tri_wave = ph[15] ? -$signed({1'b0, m[13:1]}) :
			$signed({1'b0, m[13:1]});
	endfunction

	upconv_port_pkg::ctrl_type cfg_r;
	logic [DW-1:0] data_s1_r, data_s2_r;
	logic gate_s1_r, gate_s2_r, ramp_s1_r, ramp_s2_r;

	// config register and pin synchronisers; first stages feed only the second
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_r <= upconv_port_pkg::CTRL_RST;
			data_s1_r <= '0;
			data_s2_r <= '0;
			gate_s1_r <= 1'b0;
			gate_s2_r <= 1'b0;
			ramp_s1_r <= 1'b0;
			ramp_s2_r <= 1'b0;
		end
		else
		begin
			cfg_r <= ctrl;
			data_s1_r <= port_data_pin;
			data_s2_r <= data_s1_r;
			gate_s1_r <= transmit_gate_pin;
			gate_s2_r <= gate_s1_r;
			ramp_s1_r <= amplitude_ramp_keying_pin;
			ramp_s2_r <= ramp_s1_r;
		end
	end

	logic is_quad, is_dac, is_tone, serial_mode, rate_mode;

	// mode decode steering the whole datapath
	always_comb
	begin
		is_quad = (cfg_r.mode == upconv_port_pkg::MODE_QUAD);
		is_dac = (cfg_r.mode == upconv_port_pkg::MODE_DAC);
		is_tone = (cfg_r.mode == upconv_port_pkg::MODE_TONE);
		serial_mode = is_quad && cfg_r.serial_iq;
		rate_mode = is_quad && cfg_r.rate_ctrl && !cfg_r.serial_iq;
	end

	assign i_path_en = !is_tone;
	assign q_path_en = is_quad;
	assign dds_en = !is_dac;
	assign modulator_en = is_quad;
	assign extra_halfband_en = serial_mode;

	logic [CW-1:0] cnt_r, cnt_nxt, period, half;
	logic pclk_int_r, pclk_int_nxt, pclk_pin_r, pclk_pin_nxt;
	logic rise_evt, fall_evt, act_evt, cap_evt;

	// port clock divider; edges are one-cycle enables, not a second clock
	always_comb
	begin
		period = port_period(cfg_r);
		half = period >> 1;
		rise_evt = (cnt_r == '0);
		fall_evt = (cnt_r == half);
		cnt_nxt = (cnt_r >= period - 10'h001) ? '0 : cnt_r + 10'h001;
		pclk_int_nxt = (cnt_nxt < half);
		pclk_pin_nxt = pclk_int_nxt && cfg_r.clk_enable;
		act_evt = cfg_r.clk_invert ? fall_evt : rise_evt;
		cap_evt = !is_tone && (rate_mode ? (rise_evt || fall_evt) : act_evt);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_r <= '0;
			pclk_int_r <= 1'b0;
			pclk_pin_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			pclk_int_r <= pclk_int_nxt;
			pclk_pin_r <= pclk_pin_nxt;
		end
	end

	assign port_sample_clock = pclk_pin_r;

	upconv_port_pkg::sample_type smp_r, smp_nxt;
	logic signed [DW-1:0] i_hold_r, i_hold_nxt, q_hold_r, q_hold_nxt, word;
	logic [SW-1:0] sh_i_r, sh_i_nxt, sh_q_r, sh_q_nxt;
	logic [3:0] bitcnt_r, bitcnt_nxt, bc;
	logic gate_prev_r, gate_prev_nxt, expect_i_r, expect_i_nxt;
	logic gate_now, first, is_i, bit_i, bit_q;

	// word capture, gating and I/Q pairing
	always_comb
	begin
		smp_nxt = smp_r;
		smp_nxt.valid = 1'b0;
		i_hold_nxt = i_hold_r;
		q_hold_nxt = q_hold_r;
		sh_i_nxt = sh_i_r;
		sh_q_nxt = sh_q_r;
		bitcnt_nxt = bitcnt_r;
		gate_prev_nxt = gate_prev_r;
		expect_i_nxt = expect_i_r;
		gate_now = gate_s2_r ^ cfg_r.gate_invert;
		first = gate_now && !gate_prev_r;
		word = fmt_word(data_s2_r, cfg_r.offset_bin);
		bit_i = data_s2_r[upconv_port_pkg::PIN_SER_I];
		bit_q = data_s2_r[upconv_port_pkg::PIN_SER_Q];
		bc = first ? 4'h0 : bitcnt_r;
		is_i = rate_mode ? act_evt :
			(first ? !cfg_r.q_first : expect_i_r);
		if (is_tone)
		begin
			smp_nxt.i = '0;
			smp_nxt.q = '0;
		end
		else if (cap_evt)
		begin
			gate_prev_nxt = gate_now;
			if (!gate_now)
			begin
				bitcnt_nxt = 4'h0;
				if (!cfg_r.hold_last)
				begin
					smp_nxt.i = '0;
					smp_nxt.q = '0;
					i_hold_nxt = '0;
					q_hold_nxt = '0;
				end
			end
			else if (serial_mode)
			begin
				sh_i_nxt = cfg_r.lsb_first ? {bit_i, sh_i_r[SW-1:1]} :
					{sh_i_r[SW-2:0], bit_i};
				sh_q_nxt = cfg_r.lsb_first ? {bit_q, sh_q_r[SW-1:1]} :
					{sh_q_r[SW-2:0], bit_q};
				bitcnt_nxt = bc + 4'h1;
				if (bc == upconv_port_pkg::SER_LAST)
				begin
					smp_nxt.valid = 1'b1;
					smp_nxt.i = fmt_word({sh_i_nxt, 2'h0}, cfg_r.offset_bin);
					smp_nxt.q = fmt_word({sh_q_nxt, 2'h0}, cfg_r.offset_bin);
				end
			end
			else if (is_dac)
			begin
				smp_nxt.valid = 1'b1;
				smp_nxt.i = word;
				smp_nxt.q = '0;
			end
			else
			begin
				expect_i_nxt = !is_i;
				if (is_i)
					i_hold_nxt = word;
				else
					q_hold_nxt = word;
				if (is_i == cfg_r.q_first)
				begin
					smp_nxt.valid = 1'b1;
					smp_nxt.i = is_i ? word : i_hold_r;
					smp_nxt.q = is_i ? q_hold_r : word;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			smp_r <= upconv_port_pkg::SAMPLE_RST;
			i_hold_r <= '0;
			q_hold_r <= '0;
			sh_i_r <= '0;
			sh_q_r <= '0;
			bitcnt_r <= 4'h0;
			gate_prev_r <= 1'b0;
			expect_i_r <= 1'b1;
		end
		else
		begin
			smp_r <= smp_nxt;
			i_hold_r <= i_hold_nxt;
			q_hold_r <= q_hold_nxt;
			sh_i_r <= sh_i_nxt;
			sh_q_r <= sh_q_nxt;
			bitcnt_r <= bitcnt_nxt;
			gate_prev_r <= gate_prev_nxt;
			expect_i_r <= expect_i_nxt;
		end
	end

	assign baseband_sample = smp_r;

	logic signed [DW-1:0] i_acc_r, i_acc_nxt, q_acc_r, q_acc_nxt;
	logic signed [DW-1:0] i_prev_r, i_prev_nxt, q_prev_r, q_prev_nxt;
	logic [31:0] phase_r, phase_nxt;
	logic [upconv_port_pkg::AMP_W-1:0] amp_r, amp_nxt, target;
	logic [15:0] ramp_cnt_r, ramp_cnt_nxt;

	// zero-stuffed comb then integrator at the converter rate; first order
	// only, so image rejection is modest; carrier phase and amplitude ramp
	always_comb
	begin
		i_prev_nxt = smp_r.valid ? smp_r.i : i_prev_r;
		q_prev_nxt = smp_r.valid ? smp_r.q : q_prev_r;
		i_acc_nxt = smp_r.valid ? DW'(i_acc_r + smp_r.i - i_prev_r) :
			i_acc_r;
		q_acc_nxt = (smp_r.valid && is_quad) ?
			DW'(q_acc_r + smp_r.q - q_prev_r) : (is_quad ? q_acc_r : '0);
		phase_nxt = dds_en ? phase_r + cfg_r.tuning : '0;
		target = (!cfg_r.ramp_en || ramp_s2_r) ? cfg_r.amp_preset : '0;
		ramp_cnt_nxt = ramp_cnt_r + 16'h0001;
		amp_nxt = amp_r;
		if (!cfg_r.ramp_en)
			amp_nxt = cfg_r.amp_preset;
		else if (ramp_cnt_r >= cfg_r.ramp_step_cycles)
		begin
			ramp_cnt_nxt = 16'h0000;
			if (amp_r < target)
				amp_nxt = amp_r + 14'h0001;
			else if (amp_r > target)
				amp_nxt = amp_r - 14'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			i_acc_r <= '0;
			q_acc_r <= '0;
			i_prev_r <= '0;
			q_prev_r <= '0;
			phase_r <= '0;
			amp_r <= '0;
			ramp_cnt_r <= 16'h0000;
		end
		else
		begin
			i_acc_r <= i_acc_nxt;
			q_acc_r <= q_acc_nxt;
			i_prev_r <= i_prev_nxt;
			q_prev_r <= q_prev_nxt;
			phase_r <= phase_nxt;
			amp_r <= amp_nxt;
			ramp_cnt_r <= ramp_cnt_nxt;
		end
	end

	logic signed [OW-1:0] sin_w, cos_w, tone_w, mod_w, y_w;
	logic signed [OW-1:0] x0_r, x0_nxt, x1_r, x1_nxt, x2_r, x2_nxt;
	logic signed [OW-1:0] dac_r, dac_nxt;
	logic signed [31:0] prod_i, prod_q, tone_p, sinc_s, gain_p;

	// modulator, tone scaling, inverse sinc and output gain
	always_comb
	begin
		sin_w = tri_wave(phase_r[31:16]);
		cos_w = tri_wave(phase_r[31:16] + upconv_port_pkg::PHASE_QUARTER);
		prod_i = i_acc_r * cos_w;
		prod_q = q_acc_r * sin_w;
		mod_w = sat_dac(((prod_i >>> 1) + (prod_q >>> 1)) >>>
			upconv_port_pkg::MOD_SHIFT);
		tone_p = (cfg_r.sine_sel ? sin_w : cos_w) *
			$signed({1'b0, amp_r});
		tone_w = OW'(tone_p >>> upconv_port_pkg::TONE_SHIFT);
		if (is_tone)
			x0_nxt = tone_w;
		else if (is_dac)
			x0_nxt = OW'(i_acc_r >>> upconv_port_pkg::INTERP_SHIFT);
		else
			x0_nxt = mod_w;
		x1_nxt = x0_r;
		x2_nxt = x1_r;
		sinc_s = (x1_r * upconv_port_pkg::SINC_CENTER - x0_r - x2_r) >>>
			upconv_port_pkg::SINC_SHIFT;
		y_w = cfg_r.inv_sinc_en ? sat_dac(sinc_s) : x1_r;
		gain_p = y_w * $signed({1'b0, cfg_r.out_gain});
		dac_nxt = sat_dac(gain_p >>> upconv_port_pkg::GAIN_SHIFT);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			x0_r <= '0;
			x1_r <= '0;
			x2_r <= '0;
			dac_r <= '0;
		end
		else
		begin
			x0_r <= x0_nxt;
			x1_r <= x1_nxt;
			x2_r <= x2_nxt;
			dac_r <= dac_nxt;
		end
	end

	assign dac_code = dac_r;

	// checks on the port behaviour
	sequence s_gate_rise;
		cap_evt && gate_now && !gate_prev_r && !is_tone;
	endsequence
	sequence s_last_bit;
		serial_mode && cap_evt && gate_now && gate_prev_r &&
			bitcnt_r == upconv_port_pkg::SER_LAST;
	endsequence

	property p_tone_idle;
		@(posedge clk) disable iff (!rst_b)
		is_tone && $past(is_tone) |-> !smp_r.valid && smp_r.i == '0;
	endproperty
	a_tone_idle: assert property (p_tone_idle)
		else $error("sample produced in tone mode");

	property p_clk_off;
		@(posedge clk) disable iff (!rst_b)
		!cfg_r.clk_enable |=> !port_sample_clock;
	endproperty
	a_clk_off: assert property (p_clk_off)
		else $error("port clock pin not low while disabled");

	property p_clk_follow;
		@(posedge clk) disable iff (!rst_b)
		cfg_r.clk_enable && $past(cfg_r.clk_enable) |->
			port_sample_clock == pclk_int_r;
	endproperty
	a_clk_follow: assert property (p_clk_follow)
		else $error("port clock pin differs from internal clock");

	property p_gated;
		@(posedge clk) disable iff (!rst_b)
		smp_r.valid |-> gate_prev_r && $past(cap_evt);
	endproperty
	a_gated: assert property (p_gated)
		else $error("sample taken without gate or edge");

	property p_zero_fill;
		@(posedge clk) disable iff (!rst_b)
		cap_evt && !gate_now && !cfg_r.hold_last && !is_tone |=>
			smp_r.i == '0 && smp_r.q == '0;
	endproperty
	a_zero_fill: assert property (p_zero_fill)
		else $error("idle gate did not zero the words");

	property p_dac_q;
		@(posedge clk) disable iff (!rst_b)
		smp_r.valid && is_dac |-> smp_r.q == '0 && q_acc_r == '0;
	endproperty
	a_dac_q: assert property (p_dac_q)
		else $error("Q path active in DAC mode");

	property p_first_i;
		@(posedge clk) disable iff (!rst_b)
		s_gate_rise and (is_quad && !serial_mode && !rate_mode &&
			!cfg_r.q_first) |=> !expect_i_r && !smp_r.valid;
	endproperty
	a_first_i: assert property (p_first_i)
		else $error("first word after gate rise not taken as I");

	property p_serial_word;
		@(posedge clk) disable iff (!rst_b)
		s_last_bit |=> smp_r.valid ##1 !smp_r.valid;
	endproperty
	a_serial_word: assert property (p_serial_word)
		else $error("serial word not delivered on sixteenth bit");

	property p_ramp_step;
		@(posedge clk) disable iff (!rst_b)
		cfg_r.ramp_en && $past(cfg_r.ramp_en) && amp_r != $past(amp_r) |->
			(amp_r == $past(amp_r) + 14'h0001 ||
			amp_r == $past(amp_r) - 14'h0001);
	endproperty
	a_ramp_step: assert property (p_ramp_step)
		else $error("amplitude ramp jumped");
endmodule // baseband_data_input_port

// ---- dv/data_source_model.sv ----
// baseband data source model that drives words and gate against the port clock
`timescale 1ns/1ps
module data_source_model #(
	parameter int LAG = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// port clock and settings seen from the device
	input wire logic port_sample_clock,
	input wire logic clk_invert,
	input wire logic both_edges,
	input wire logic gate_invert,
	// pins into the device
	output logic [upconv_port_pkg::DATA_W-1:0] port_data_pin,
	output logic transmit_gate_pin
);
	localparam int W = upconv_port_pkg::DATA_W;
	logic [W:0] items[$];
	logic [W:0] cur;
	logic pclk_d_r;
	int wait_n;

	// queue one word with its gate truth level in the top bit
	task automatic push(input logic [W:0] it);
		items.push_back(it);
	endtask

	// new word a few clocks after the edge so it is settled at the next
	// capture; idle means gate false and data that never sits still
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pclk_d_r <= 1'b0;
			wait_n <= 0;
			port_data_pin <= '0;
			transmit_gate_pin <= 1'b0;
		end
		else
		begin
			pclk_d_r <= port_sample_clock;
			if (port_sample_clock != pclk_d_r &&
				(both_edges || port_sample_clock != clk_invert))
				wait_n <= LAG;
			else if (wait_n > 0)
				wait_n <= wait_n - 1;
			if (wait_n == 1)
			begin
				if (items.size() > 0)
				begin
					cur = items.pop_front();
					port_data_pin <= cur[W-1:0];
					transmit_gate_pin <= cur[W] ^ gate_invert;
				end
				else
				begin
					port_data_pin <= ~port_data_pin;
					transmit_gate_pin <= gate_invert;
				end
			end
		end
	end
endmodule // data_source_model

// ---- dv/tb.sv ----
// self-checking bench for the baseband data input port
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			n_fail++; \
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
		end \
	end
module tb;
	typedef struct {
		upconv_port_pkg::op_mode_type mode;
		logic serial_iq;
		logic rate_ctrl;
		logic [5:0] ratio;
		int period;
	} row_type;
	localparam int W = upconv_port_pkg::DATA_W;
	localparam logic [15:0] SW_I = 16'hA5C3;
	localparam logic [15:0] SW_Q = 16'h3C5A;
	logic clk;
	logic rst_b;
	upconv_port_pkg::ctrl_type ctrl;
	upconv_port_pkg::ctrl_type c;
	logic [W-1:0] port_data_pin;
	logic transmit_gate_pin;
	logic amplitude_ramp_keying_pin;
	logic port_sample_clock;
	logic i_path_en, q_path_en, dds_en, modulator_en, extra_halfband_en;
	upconv_port_pkg::sample_type baseband_sample;
	logic [upconv_port_pkg::DAC_W-1:0] dac_code;
	upconv_port_pkg::sample_type got[$];
	int n_fail = 0;
	int comparisons = 0;
	int hi;
	int bi;
	time t0;
	logic [W-1:0] vec[4] = '{18'h1FFFF, 18'h20000, 18'h00001, 18'h3FFFF};
	// small ratios and the zero and minimum-period corners
	row_type rows[6] = '{
		'{upconv_port_pkg::MODE_QUAD, 1'b0, 1'b0, 6'h03, 6},
		'{upconv_port_pkg::MODE_QUAD, 1'b0, 1'b1, 6'h03, 12},
		'{upconv_port_pkg::MODE_DAC, 1'b0, 1'b0, 6'h02, 8},
		'{upconv_port_pkg::MODE_QUAD, 1'b1, 1'b0, 6'h05, 5},
		'{upconv_port_pkg::MODE_QUAD, 1'b0, 1'b0, 6'h00, 2},
		'{upconv_port_pkg::MODE_QUAD, 1'b1, 1'b0, 6'h01, 2}};

	baseband_data_input_port baseband_data_input_port_inst (
		.clk(clk),
		.rst_b(rst_b),
		.ctrl(ctrl),
		.port_data_pin(port_data_pin),
		.transmit_gate_pin(transmit_gate_pin),
		.amplitude_ramp_keying_pin(amplitude_ramp_keying_pin),
		.port_sample_clock(port_sample_clock),
		.i_path_en(i_path_en),
		.q_path_en(q_path_en),
		.dds_en(dds_en),
		.modulator_en(modulator_en),
		.extra_halfband_en(extra_halfband_en),
		.baseband_sample(baseband_sample),
		.dac_code(dac_code)
	);

	data_source_model data_source_model_inst (
		.clk(clk),
		.rst_b(rst_b),
		.port_sample_clock(port_sample_clock),
		.clk_invert(ctrl.clk_invert),
		.both_edges(ctrl.rate_ctrl),
		.gate_invert(ctrl.gate_invert),
		.port_data_pin(port_data_pin),
		.transmit_gate_pin(transmit_gate_pin)
	);

	// unity settings with the port clock visible and a slow port
	function automatic upconv_port_pkg::ctrl_type base();
		upconv_port_pkg::ctrl_type v;
		v = '0;
		v.clk_enable = 1'b1;
		v.ratio = 6'h10;
		v.out_gain = 8'h80;
		return v;
	endfunction

	// long settle so the divider and any stale pairing are flushed
	task automatic setcfg(input upconv_port_pkg::ctrl_type v);
		@(posedge clk);
		ctrl <= v;
		repeat (140) @(posedge clk);
		got.delete();
	endtask

	task automatic put(input logic g, input logic [W-1:0] w);
		data_source_model_inst.push({g, w});
	endtask

	task automatic drain();
		int n;
		n = 0;
		while (data_source_model_inst.items.size() > 0 && n < 4000)
		begin
			@(posedge clk);
			n++;
		end
		repeat (140) @(posedge clk);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// collect every completed sample mid-cycle, where it has settled
	always @(negedge clk)
		if (baseband_sample.valid === 1'b1)
			got.push_back(baseband_sample);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// cut a hang short well past the expected run length
	initial
	begin
		repeat (40000) @(posedge clk);
		n_fail++;
		end_of_test();
	end

	initial
	begin
		rst_b = 1'b0;
		ctrl = '0;
		amplitude_ramp_keying_pin = 1'b1;
		repeat (8) @(posedge clk);
		`CHK("rst_dds", 1'b1, dds_en)
		`CHK("rst_q", 1'b1, q_path_en)
		`CHK("rst_valid", 1'b0, baseband_sample.valid)
		rst_b <= 1'b1;
		// port clock period and path enables per mode
		foreach (rows[k])
		begin
			c = base();
			c.mode = rows[k].mode;
			c.serial_iq = rows[k].serial_iq;
			c.rate_ctrl = rows[k].rate_ctrl;
			c.ratio = rows[k].ratio;
			setcfg(c);
			@(posedge port_sample_clock);
			t0 = $time;
			@(posedge port_sample_clock);
			`CHK("period", rows[k].period, int'(($time - t0) / 5))
			`CHK("halfband", rows[k].serial_iq, extra_halfband_en)
			`CHK("q_en", c.mode == upconv_port_pkg::MODE_QUAD, q_path_en)
		end
		// plain quadrature pairing with extreme words, zero when idle
		setcfg(base());
		foreach (vec[k]) put(1'b1, vec[k]);
		drain();
		`CHK("pairs", 2, got.size())
		`CHK("i0", vec[0], got[0].i)
		`CHK("q0", vec[1], got[0].q)
		`CHK("i1", vec[2], got[1].i)
		`CHK("q1", vec[3], got[1].q)
		`CHK("idle_zero", 18'h00000, baseband_sample.i)
		// q first, inverted gate, offset binary, hold last value
		c = base();
		c.q_first = 1'b1;
		c.gate_invert = 1'b1;
		c.hold_last = 1'b1;
		c.offset_bin = 1'b1;
		setcfg(c);
		put(1'b1, vec[0]);
		put(1'b1, vec[1]);
		drain();
		`CHK("qf_i", vec[1] ^ 18'h20000, got[0].i)
		`CHK("qf_q", vec[0] ^ 18'h20000, got[0].q)
		`CHK("held", vec[1] ^ 18'h20000, baseband_sample.i)
		// gate drop mid-burst: word ignored and order restarts
		setcfg(base());
		put(1'b1, vec[0]);
		put(1'b0, vec[1]);
		put(1'b1, vec[2]);
		put(1'b1, vec[3]);
		drain();
		`CHK("gap_n", 1, got.size())
		`CHK("gap_i", vec[2], got[0].i)
		`CHK("gap_q", vec[3], got[0].q)
		// half rate, inverted: I on falling edge, Q on rising edge
		c = base();
		c.rate_ctrl = 1'b1;
		c.clk_invert = 1'b1;
		setcfg(c);
		@(posedge port_sample_clock);
		put(1'b1, vec[0]);
		put(1'b1, vec[1]);
		drain();
		`CHK("rc_i", vec[0], got[0].i)
		`CHK("rc_q", vec[1], got[0].q)
		// dac mode: odd count, every word a sample, no Q path
		c = base();
		c.mode = upconv_port_pkg::MODE_DAC;
		setcfg(c);
		for (int k = 0; k < 3; k++) put(1'b1, vec[k]);
		drain();
		`CHK("dac_n", 3, got.size())
		`CHK("dac_i", vec[2], got[2].i)
		`CHK("dac_q", 18'h00000, got[0].q)
		`CHK("dac_dds", 1'b0, dds_en)
		`CHK("dac_mod", 1'b0, modulator_en)
		// gate run as a clock at half the word rate: every other word dropped
		got.delete();
		for (int k = 0; k < 4; k++) put(k[0] == 1'b0, vec[k]);
		drain();
		`CHK("gclk_n", 2, got.size())
		`CHK("gclk_i", vec[2], got[1].i)
		// pin held low while capture goes on behind it
		for (int k = 0; k < 40; k++) put(1'b1, vec[3]);
		repeat (200) @(posedge clk);
		ctrl.clk_enable <= 1'b0;
		repeat (3) @(posedge clk);
		got.delete();
		hi = 0;
		repeat (300)
		begin
			@(posedge clk);
			hi += (port_sample_clock !== 1'b0);
		end
		`CHK("pin_off", 0, hi)
		`CHK("capturing", 1'b1, got.size() > 0)
		ctrl.clk_enable <= 1'b1;
		drain();
		// tone mode takes no data
		c = base();
		c.mode = upconv_port_pkg::MODE_TONE;
		c.tuning = 32'h01000000;
		c.amp_preset = 14'h0100;
		c.ramp_en = 1'b1;
		c.ramp_step_cycles = 16'h0000;
		c.sine_sel = 1'b1;
		c.inv_sinc_en = 1'b1;
		setcfg(c);
		put(1'b1, vec[0]);
		put(1'b1, vec[1]);
		drain();
		`CHK("tone_n", 0, got.size())
		`CHK("tone_i_en", 1'b0, i_path_en)
		`CHK("tone_mod", 1'b0, modulator_en)
		`CHK("tone_dds", 1'b1, dds_en)
		// keying pin low ramps the scale to zero, so the converter goes quiet
		amplitude_ramp_keying_pin <= 1'b0;
		repeat (400) @(posedge clk);
		hi = 0;
		repeat (64)
		begin
			@(negedge clk);
			hi += (dac_code !== 14'h0000);
		end
		`CHK("ramp_zero", 0, hi)
		// keying pin high ramps back to the preset and the tone returns
		@(posedge clk);
		amplitude_ramp_keying_pin <= 1'b1;
		repeat (400) @(posedge clk);
		hi = 0;
		repeat (64)
		begin
			@(negedge clk);
			hi += (dac_code !== 14'h0000);
		end
		`CHK("tone_out", 1'b1, hi > 0)
		// serial frames both bit orders, spare pins toggling
		for (int lsb = 0; lsb < 2; lsb++)
		begin
			c = base();
			c.serial_iq = 1'b1;
			c.lsb_first = lsb[0];
			setcfg(c);
			for (int b = 0; b < 16; b++)
			begin
				bi = lsb ? b : 15 - b;
				put(1'b1, {b[15:0] ^ 16'h5A5A, SW_Q[bi], SW_I[bi]});
			end
			drain();
			`CHK("ser_n", 1, got.size())
			`CHK("ser_i", {SW_I, 2'b00}, got[0].i)
			`CHK("ser_q", {SW_Q, 2'b00}, got[0].q)
		end
		end_of_test();
	end
endmodule // tb
